// File: src/ctw_pkg.sv
package ctw_pkg;
  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_CONTROL_ONE = 4'h0;
  localparam logic [3:0] IDX_CONTROL_TWO = 4'h1;
  localparam logic [3:0] IDX_EVENT_CONTROL = 4'h4;
  localparam logic [3:0] IDX_IRQ_ENABLE = 4'h5;
  localparam logic [3:0] IDX_IRQ_FLAG = 4'h6;
  localparam logic [3:0] IDX_RUN_STATE = 4'h7;
  localparam logic [3:0] IDX_HALT_BEHAVIOUR = 4'h8;
  localparam logic [3:0] IDX_SHARED_BYTE_BUFFER = 4'h9;
  localparam logic [3:0] IDX_COUNT_LOW = 4'hA;
  localparam logic [3:0] IDX_COUNT_HIGH = 4'hB;
  localparam logic [3:0] IDX_CAPTURE_LOW = 4'hC;
  localparam logic [3:0] IDX_CAPTURE_HIGH = 4'hD;
  localparam int ADR_LSB = 2;
  localparam int ADR_W = 6;

  // control_one fields
  localparam int BIT_ENABLE = 0;
  localparam int POS_CLOCK_CHOICE = 1;
  localparam int BIT_SYNC_RESTART = 4;
  localparam int BIT_STANDBY_RUN = 6;
  localparam logic [7:0] MASK_CONTROL_ONE = 8'h57;
  // control_two fields
  localparam int POS_MODE = 0;
  localparam int BIT_COMPARE_OUTPUT_ON = 4;
  localparam int BIT_OUTPUT_START_LEVEL = 5;
  localparam int BIT_IMMEDIATE_OUTPUT = 6;
  localparam logic [7:0] MASK_CONTROL_TWO = 8'h77;
  // event_control fields
  localparam int BIT_EVENT_INPUT_ON = 0;
  localparam int BIT_EDGE = 4;
  localparam int BIT_FILTER = 6;
  localparam logic [7:0] MASK_EVENT_CONTROL = 8'h51;
  localparam int BIT_CAPTURE_IRQ = 0;
  localparam int BIT_RUN = 0;
  localparam int BIT_RUN_IN_HALT = 0;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam int FILTER_TAPS = 4;

  typedef enum logic [1:0] {
    CLK_PERIPH = 2'h0,
    CLK_HALF = 2'h1,
    CLK_COMPANION = 2'h2,
    CLK_NONE = 2'h3
  } ctw_clk_t;

  typedef enum logic [2:0] {
    MODE_PERIODIC = 3'h0,
    MODE_TIMEOUT = 3'h1,
    MODE_CAPTURE = 3'h2,
    MODE_FREQ = 3'h3,
    MODE_PULSE = 3'h4,
    MODE_FREQ_PULSE = 3'h5,
    MODE_SINGLE = 3'h6,
    MODE_PWM = 3'h7
  } ctw_mode_t;

  // phases of frequency plus pulse-width measurement
  typedef enum logic [2:0] {
    FP_IDLE = 3'b001,
    FP_FIRST = 3'b010,
    FP_SECOND = 3'b100
  } ctw_fp_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [ADR_W-1:0] adr;
    logic [31:0] dat;
  } ctw_wb_req_t;

  typedef struct packed {
    logic [7:0] control_one;
    logic [7:0] control_two;
    logic [7:0] event_control;
    logic irq_enable;
    logic irq_flag;
    logic run_in_halt;
    logic [7:0] shared_byte_buffer;
    logic [15:0] count_value;
    logic [15:0] capture_or_top;
    logic running;
    ctw_fp_t fp_phase;
    logic half_phase;
    logic ev_meta;
    logic ev_sync;
    logic [FILTER_TAPS-1:0] ev_hist;
    logic ev_level;
    logic ev_prev;
    logic out_level;
    logic irq;
    logic ack;
    logic [31:0] rdata;
  } ctw_state_t;
endpackage : ctw_pkg

// File: src/ctw_timer.sv
// Chosen here: register access over Wishbone.
`timescale 1ns/10ps
// Operation
// - clock choice: periph, half, companion, none
// - enable bit runs the timer
// - standby run ignored under companion clock
// - sync restart follows companion restart
// - single shot output rise: start or event
// - start level sets idle output
// - output forced low unless enabled
// - mode field picks eight operating modes
// - filter bit inserts noise canceller
// - timeout edges start/stop; others ignored
// - capture mode edge captures count
// - frequency: edge captures, clears, flags
// - pulse width: init edge, capture edge
// - freq plus width: init, capture, stop
// - single shot start edge selection
// - flag cleared by one or, in capture, frequency, pulse width and freq plus width modes, capture read
// - run bit shows counting state
// - shared byte buffer for 16-bit access
// - debug halt stops unless run in halt
module ctw_timer (
  input wire logic mclk, // system clock
  input wire logic rst_n, // synchronous reset
  input wire ctw_pkg::ctw_wb_req_t wb_req, // wishbone request
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic event_in, // event channel level
  input wire logic companion_tick, // companion clock strobe
  input wire logic companion_restart, // companion counter restart
  input wire logic standby_sleep, // system in standby
  input wire logic debug_halt, // processor halted in debug
  output logic cc_out, // compare/capture output
  output logic irq_req // capture interrupt request
);
  ctw_pkg::ctw_state_t st;
  ctw_pkg::ctw_state_t next_st;

  always_comb begin
    logic enable;
    logic [1:0] clk_sel;
    logic edge_sel;
    logic [2:0] mode;
    logic active;
    logic tick;
    logic ev_ok;
    logic rise;
    logic fall;
    logic prim;
    logic secd;
    logic set_flag;
    logic clr_flag;
    logic out_ev;
    logic req;
    logic [3:0] idx;
    logic [7:0] wbyte;
    logic wr;
    logic [31:0] rd;
    logic at_top;
    logic pwm_hi;
    next_st = st;
    active = 1'b0;
    tick = 1'b0;
    ev_ok = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    prim = 1'b0;
    secd = 1'b0;
    req = 1'b0;
    idx = 4'h0;
    wbyte = 8'h00;
    wr = 1'b0;
    at_top = 1'b0;
    pwm_hi = 1'b0;
    enable = st.control_one[ctw_pkg::BIT_ENABLE];
    clk_sel = st.control_one[ctw_pkg::POS_CLOCK_CHOICE +: 2];
    edge_sel = st.event_control[ctw_pkg::BIT_EDGE];
    mode = st.control_two[ctw_pkg::POS_MODE +: 3];
    set_flag = 1'b0;
    clr_flag = 1'b0;
    out_ev = 1'b0;
    rd = 32'h00000000;

    // debug halt and standby gating
    active = enable;
    if (debug_halt && !st.run_in_halt) begin
      active = 1'b0;
    end
    if (standby_sleep && clk_sel != ctw_pkg::CLK_COMPANION &&
        !st.control_one[ctw_pkg::BIT_STANDBY_RUN]) begin
      active = 1'b0;
    end

    // counting clock selection
    next_st.half_phase = active ? ~st.half_phase : 1'b0;
    unique case (clk_sel)
      ctw_pkg::CLK_PERIPH: tick = active;
      ctw_pkg::CLK_HALF: tick = active && st.half_phase;
      ctw_pkg::CLK_COMPANION: tick = active && companion_tick;
      default: tick = 1'b0;
    endcase

    // event input: synchroniser, optional noise canceller, edge detect
    next_st.ev_meta = event_in;
    next_st.ev_sync = st.ev_meta;
    next_st.ev_hist = {st.ev_hist[ctw_pkg::FILTER_TAPS-2:0], st.ev_sync};
    if (!st.event_control[ctw_pkg::BIT_FILTER]) begin
      next_st.ev_level = st.ev_sync;
    end else if (&st.ev_hist) begin
      next_st.ev_level = 1'b1;
    end else if (~|st.ev_hist) begin
      next_st.ev_level = 1'b0;
    end
    next_st.ev_prev = st.ev_level;
    ev_ok = active && st.event_control[ctw_pkg::BIT_EVENT_INPUT_ON];
    rise = ev_ok && st.ev_level && !st.ev_prev;
    fall = ev_ok && !st.ev_level && st.ev_prev;
    prim = edge_sel ? fall : rise;
    secd = edge_sel ? rise : fall;

    // counter and mode behaviour
    at_top = st.count_value == st.capture_or_top;
    unique case (mode)
      ctw_pkg::MODE_PERIODIC, ctw_pkg::MODE_CAPTURE,
      ctw_pkg::MODE_FREQ, ctw_pkg::MODE_PULSE,
      ctw_pkg::MODE_PWM: begin
        next_st.running = active;
      end
      default: begin
        if (!enable) begin
          next_st.running = 1'b0;
        end
      end
    endcase
    if (tick && st.running) begin
      next_st.count_value = st.count_value + 16'h0001;
      unique case (mode)
        ctw_pkg::MODE_PERIODIC, ctw_pkg::MODE_TIMEOUT: begin
          if (at_top) begin
            next_st.count_value = ctw_pkg::RESET_WORD;
            set_flag = 1'b1;
          end
        end
        ctw_pkg::MODE_SINGLE: begin
          if (at_top) begin
            // hold at top until the next start
            next_st.count_value = st.count_value;
            next_st.running = 1'b0;
            set_flag = 1'b1;
          end
        end
        ctw_pkg::MODE_PWM: begin
          if (st.count_value[7:0] >= st.capture_or_top[7:0]) begin
            next_st.count_value = ctw_pkg::RESET_WORD;
          end
          if (st.count_value[7:0] == st.capture_or_top[15:8]) begin
            set_flag = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    unique case (mode)
      ctw_pkg::MODE_TIMEOUT: begin
        if (prim) begin
          next_st.running = 1'b1;
        end else if (secd) begin
          next_st.running = 1'b0;
        end
      end
      ctw_pkg::MODE_CAPTURE: begin
        if (prim) begin
          next_st.capture_or_top = st.count_value;
          set_flag = 1'b1;
        end
      end
      ctw_pkg::MODE_FREQ: begin
        if (prim) begin
          next_st.capture_or_top = st.count_value;
          next_st.count_value = ctw_pkg::RESET_WORD;
          set_flag = 1'b1;
        end
      end
      ctw_pkg::MODE_PULSE: begin
        if (prim) begin
          next_st.count_value = ctw_pkg::RESET_WORD;
        end else if (secd) begin
          next_st.capture_or_top = st.count_value;
          set_flag = 1'b1;
        end
      end
      ctw_pkg::MODE_FREQ_PULSE: begin
        unique case (st.fp_phase)
          ctw_pkg::FP_IDLE: begin
            if (prim) begin
              next_st.count_value = ctw_pkg::RESET_WORD;
              next_st.running = 1'b1;
              next_st.fp_phase = ctw_pkg::FP_FIRST;
            end
          end
          ctw_pkg::FP_FIRST: begin
            if (secd) begin
              next_st.capture_or_top = st.count_value;
              next_st.fp_phase = ctw_pkg::FP_SECOND;
            end
          end
          ctw_pkg::FP_SECOND: begin
            if (prim) begin
              next_st.running = 1'b0;
              set_flag = 1'b1;
              next_st.fp_phase = ctw_pkg::FP_IDLE;
            end
          end
          default: next_st.fp_phase = ctw_pkg::FP_IDLE;
        endcase
      end
      ctw_pkg::MODE_SINGLE: begin
        if ((edge_sel ? (rise || fall) : rise) && !st.running) begin
          next_st.count_value = ctw_pkg::RESET_WORD;
          next_st.running = 1'b1;
          out_ev = 1'b1;
        end
      end
      default: begin
      end
    endcase
    if (mode != ctw_pkg::MODE_FREQ_PULSE || !enable) begin
      next_st.fp_phase = ctw_pkg::FP_IDLE;
    end
    if (st.control_one[ctw_pkg::BIT_SYNC_RESTART] && companion_restart &&
        enable) begin
      next_st.count_value = ctw_pkg::RESET_WORD;
    end

    // wishbone slave: answer one cycle after the request is seen
    req = wb_req.cyc && wb_req.stb && !st.ack;
    idx = wb_req.adr[ctw_pkg::ADR_W-1:ctw_pkg::ADR_LSB];
    wbyte = wb_req.dat[7:0];
    wr = req && wb_req.we && wb_req.sel[0];
    next_st.ack = req;
    unique case (idx)
      ctw_pkg::IDX_CONTROL_ONE: begin
        rd[7:0] = st.control_one;
        if (wr) begin
          next_st.control_one = wbyte & ctw_pkg::MASK_CONTROL_ONE;
        end
      end
      ctw_pkg::IDX_CONTROL_TWO: begin
        rd[7:0] = st.control_two;
        if (wr) begin
          next_st.control_two = wbyte & ctw_pkg::MASK_CONTROL_TWO;
        end
      end
      ctw_pkg::IDX_EVENT_CONTROL: begin
        rd[7:0] = st.event_control;
        if (wr) begin
          next_st.event_control = wbyte & ctw_pkg::MASK_EVENT_CONTROL;
        end
      end
      ctw_pkg::IDX_IRQ_ENABLE: begin
        rd[ctw_pkg::BIT_CAPTURE_IRQ] = st.irq_enable;
        if (wr) begin
          next_st.irq_enable = wbyte[ctw_pkg::BIT_CAPTURE_IRQ];
        end
      end
      ctw_pkg::IDX_IRQ_FLAG: begin
        rd[ctw_pkg::BIT_CAPTURE_IRQ] = st.irq_flag;
        if (wr && wbyte[ctw_pkg::BIT_CAPTURE_IRQ]) begin
          clr_flag = 1'b1;
        end
      end
      ctw_pkg::IDX_RUN_STATE: begin
        rd[ctw_pkg::BIT_RUN] = st.running;
      end
      ctw_pkg::IDX_HALT_BEHAVIOUR: begin
        rd[ctw_pkg::BIT_RUN_IN_HALT] = st.run_in_halt;
        if (wr) begin
          next_st.run_in_halt = wbyte[ctw_pkg::BIT_RUN_IN_HALT];
        end
      end
      ctw_pkg::IDX_SHARED_BYTE_BUFFER: begin
        rd[7:0] = st.shared_byte_buffer;
        if (wr) begin
          next_st.shared_byte_buffer = wbyte;
        end
      end
      ctw_pkg::IDX_COUNT_LOW: begin
        rd[7:0] = st.count_value[7:0];
        if (wr) begin
          next_st.shared_byte_buffer = wbyte;
        end else if (req) begin
          next_st.shared_byte_buffer = st.count_value[15:8];
        end
      end
      ctw_pkg::IDX_COUNT_HIGH: begin
        rd[7:0] = st.shared_byte_buffer;
        if (wr) begin
          next_st.count_value = {wbyte, st.shared_byte_buffer};
        end
      end
      ctw_pkg::IDX_CAPTURE_LOW: begin
        rd[7:0] = st.capture_or_top[7:0];
        if (wr) begin
          next_st.shared_byte_buffer = wbyte;
        end else if (req) begin
          next_st.shared_byte_buffer = st.capture_or_top[15:8];
          if (mode >= ctw_pkg::MODE_CAPTURE &&
              mode <= ctw_pkg::MODE_FREQ_PULSE) begin
            clr_flag = 1'b1;
          end
        end
      end
      ctw_pkg::IDX_CAPTURE_HIGH: begin
        rd[7:0] = st.shared_byte_buffer;
        if (wr) begin
          next_st.capture_or_top = {wbyte, st.shared_byte_buffer};
        end
      end
      default: rd = 32'h00000000;
    endcase
    next_st.rdata = req ? rd : 32'h00000000;

    // hardware set wins over a clear in the same cycle
    if (set_flag) begin
      next_st.irq_flag = 1'b1;
    end else if (clr_flag) begin
      next_st.irq_flag = 1'b0;
    end
    next_st.irq = next_st.irq_flag && next_st.irq_enable;

    // output level per mode
    pwm_hi = st.count_value[7:0] < st.capture_or_top[15:8];
    unique case (mode)
      ctw_pkg::MODE_SINGLE: begin
        if (st.control_two[ctw_pkg::BIT_IMMEDIATE_OUTPUT]) begin
          next_st.out_level = next_st.running || out_ev;
        end else begin
          next_st.out_level = st.running && next_st.running;
        end
      end
      ctw_pkg::MODE_PWM: begin
        next_st.out_level = enable && pwm_hi;
      end
      default: begin
        next_st.out_level =
          st.control_two[ctw_pkg::BIT_OUTPUT_START_LEVEL];
      end
    endcase
    if (!st.control_two[ctw_pkg::BIT_COMPARE_OUTPUT_ON]) begin
      next_st.out_level = 1'b0;
    end

    if (!rst_n) begin
      next_st = '0;
      next_st.fp_phase = ctw_pkg::FP_IDLE;
      next_st.control_one = ctw_pkg::RESET_BYTE;
      next_st.control_two = ctw_pkg::RESET_BYTE;
      next_st.event_control = ctw_pkg::RESET_BYTE;
      next_st.shared_byte_buffer = ctw_pkg::RESET_BYTE;
      next_st.count_value = ctw_pkg::RESET_WORD;
      next_st.capture_or_top = ctw_pkg::RESET_WORD;
    end
  end

  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  assign wb_dat_o = st.rdata;
  assign wb_ack_o = st.ack;
  assign cc_out = st.out_level;
  assign irq_req = st.irq;
endmodule : ctw_timer

// File: sim/ctw_timer_properties.sv
`timescale 1ns/10ps
module ctw_timer_properties (
  input wire logic mclk, // clock
  input wire logic rst_n, // reset
  input wire ctw_pkg::ctw_wb_req_t wb_req, // bus request
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // acknowledge
  input wire logic event_in, // event level
  input wire logic companion_tick, // companion strobe
  input wire logic companion_restart, // companion restart
  input wire logic standby_sleep, // standby
  input wire logic debug_halt, // debug halt
  input wire logic cc_out, // output pin
  input wire logic irq_req // interrupt
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  logic [7:0] c1, c2, c2_q, ev;
  logic ie;
  // shadows of the control bytes as software wrote them
  always_ff @(posedge mclk) begin
    c2_q <= c2;
    if (!rst_n) begin
      c1 <= 8'h00;
      c2 <= 8'h00;
      ev <= 8'h00;
      ie <= 1'b0;
    end else if (wb_req.cyc && wb_req.stb && wb_req.we && wb_req.sel[0]
        && !wb_ack_o) begin
      case (wb_req.adr[5:2])
        4'h0: c1 <= wb_req.dat[7:0];
        4'h1: c2 <= wb_req.dat[7:0];
        4'h4: ev <= wb_req.dat[7:0];
        4'h5: ie <= wb_req.dat[0];
        default: ;
      endcase
    end
  end
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge stood longer than one cycle");
  ack_latency_a:
    assert property (wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered one cycle later");
  upper_zero_a:
    assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("unused read data bits not zero");
  unmapped_zero_a:
    assert property (wb_ack_o && !wb_req.we
      && wb_req.adr[5:3] inside {3'h1, 3'h7} |-> wb_dat_o == 32'h0)
    else $error("unmapped register read not zero");
  reset_out_a:
    assert property ($rose(rst_n) |-> !cc_out && !irq_req)
    else $error("outputs not low after reset");
  forced_low_a:
    assert property (!c2[4] && !c2_q[4] |-> !cc_out)
    else $error("output high while compare output off");
  start_level_a:
    assert property (c2[4] && c2 == c2_q && c2[2:1] != 2'h3
      |-> cc_out == c2[5])
    else $error("output differs from start level");
  freq_irq_a:
    assert property ($rose(event_in) && c1[2:0] == 3'h1 && c2[2:0] == 3'h3
      && ev[6:0] == 7'h01 && ie && !debug_halt && !standby_sleep
      |-> ##[2:6] irq_req)
    else $error("frequency capture raised no interrupt");
  cover property (wb_ack_o && wb_req.we);
  cover property ($rose(irq_req));
  cover property ($rose(cc_out));
endmodule : ctw_timer_properties
bind ctw_timer ctw_timer_properties chk (.mclk(mclk), .rst_n(rst_n),
  .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .event_in(event_in), .companion_tick(companion_tick),
  .companion_restart(companion_restart), .standby_sleep(standby_sleep),
  .debug_halt(debug_halt), .cc_out(cc_out), .irq_req(irq_req));

// File: sim/ctw_far_end.sv
`timescale 1ns/10ps
module ctw_far_end (
  input wire logic mclk, // clock
  input wire logic rst_n, // reset
  input wire logic ev_want, // level asked by the bench
  output logic event_in, // routed event level
  output logic companion_tick, // companion counting strobe
  output logic companion_restart // companion counter restart
);
  logic [3:0] phase;
  // companion ticks every fourth cycle and restarts every fourth tick
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phase <= 4'h0;
      event_in <= 1'b0;
      companion_tick <= 1'b0;
      companion_restart <= 1'b0;
    end else begin
      phase <= phase + 4'h1;
      event_in <= ev_want;
      companion_tick <= phase[1:0] == 2'h3;
      companion_restart <= phase == 4'hF;
    end
  end
endmodule : ctw_far_end

// File: sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  ctw_pkg::ctw_wb_req_t wb_req = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, event_in, companion_tick, companion_restart;
  logic cc_out, irq_req;
  logic ev_want = 1'b0;
  logic standby_sleep = 1'b0;
  logic debug_halt = 1'b0;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #5 mclk = ~mclk;
  ctw_timer dut (.mclk(mclk), .rst_n(rst_n), .wb_req(wb_req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .event_in(event_in),
    .companion_tick(companion_tick), .companion_restart(companion_restart),
    .standby_sleep(standby_sleep), .debug_halt(debug_halt),
    .cc_out(cc_out), .irq_req(irq_req));
  ctw_far_end far (.mclk(mclk), .rst_n(rst_n), .ev_want(ev_want),
    .event_in(event_in), .companion_tick(companion_tick),
    .companion_restart(companion_restart));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus(input logic w, input logic [3:0] idx,
      input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk);
    wb_req <= '{1'b1, 1'b1, w, 4'h1, {idx, 2'h0}, {24'h0, d}};
    do @(posedge mclk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_req <= '0;
  endtask : bus
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr
  task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    check("register", q, exp);
  endtask : rd
  task automatic test_regs();
    logic [3:0] idx [9] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'h7,
      4'h2, 4'hE};
    logic [7:0] exp [9] = '{8'h57, 8'h77, 8'h51, 8'h01, 8'h01, 8'hFF,
      8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 16; i++) rd(4'(i), 8'h00);
    for (int i = 0; i < 9; i++) begin
      wr(idx[i], 8'hFF);
      rd(idx[i], exp[i]);
      wr(idx[i], 8'h00);
    end
    wr(4'hA, 8'h34);
    wr(4'hB, 8'h12);
    rd(4'hA, 8'h34);
    rd(4'h9, 8'h12);
    rd(4'hB, 8'h12);
    wr(4'h9, 8'h5A);
    rd(4'h9, 8'h5A);
    wr(4'hC, 8'hFF);
    wr(4'hD, 8'h00);
    rd(4'hC, 8'hFF);
    $display("register test done");
  endtask : test_regs
  task automatic test_clock();
    logic [7:0] cfg [9] = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h01, 8'h01,
      8'h41, 8'h05, 8'h11};
    logic [1:0] env [9] = '{0, 0, 0, 0, 2, 1, 1, 1, 0};
    int lo [9] = '{39, 19, 8, 0, 0, 0, 39, 8, 0};
    int hi [9] = '{45, 23, 12, 0, 0, 0, 45, 12, 16};
    logic [7:0] q;
    logic ok;
    for (int i = 0; i < 9; i++) begin
      wr(4'hA, 8'h00);
      wr(4'hB, 8'h00);
      {debug_halt, standby_sleep} <= env[i];
      wr(4'h0, cfg[i]);
      repeat (40) @(posedge mclk);
      wr(4'h0, 8'h00);
      bus(1'b0, 4'hA, 8'h00, q);
      ok = q >= lo[i] && q <= hi[i];
      check("count", ok, 16'h1);
    end
    {debug_halt, standby_sleep} <= 2'h0;
    $display("clock test done");
  endtask : test_clock
  task automatic test_output();
    logic [7:0] v [4] = '{8'h30, 8'h20, 8'h10, 8'h00};
    for (int i = 0; i < 4; i++) begin
      wr(4'h1, v[i]);
      repeat (3) @(posedge mclk);
      check("cc_out", cc_out, 16'(i == 0));
    end
    $display("output test done");
  endtask : test_output
  task automatic test_freq();
    logic [7:0] q;
    wr(4'h1, 8'h03);
    wr(4'h5, 8'h01);
    for (int e = 0; e < 2; e++) begin
      wr(4'h4, e ? 8'h11 : 8'h01);
      wr(4'h0, 8'h01);
      ev_want <= 1'b1;
      repeat (10) @(posedge mclk);
      check("irq after rise", irq_req, 16'(e == 0));
      wr(4'h6, 8'h01);
      repeat (3) @(posedge mclk);
      check("irq after clear", irq_req, 16'h0);
      ev_want <= 1'b0;
      repeat (10) @(posedge mclk);
      check("irq after fall", irq_req, 16'(e == 1));
      bus(1'b0, 4'hC, 8'h00, q);
      repeat (3) @(posedge mclk);
      check("irq after read", irq_req, 16'h0);
      wr(4'h0, 8'h00);
    end
    $display("frequency test done");
  endtask : test_freq
  task automatic shot(input logic lvl, input logic run);
    ev_want <= lvl;
    repeat (6) @(posedge mclk);
    rd(4'h7, {7'h0, run});
    check("shot output", cc_out, 16'(run));
    repeat (30) @(posedge mclk);
    rd(4'h7, 8'h00);
    check("shot end", cc_out, 16'h0);
  endtask : shot
  task automatic test_shot();
    // top 0x0010 and count preset to top so enabling alone starts nothing
    wr(4'hC, 8'h10);
    wr(4'hD, 8'h00);
    wr(4'hA, 8'h10);
    wr(4'hB, 8'h00);
    wr(4'h1, 8'h56);
    wr(4'h4, 8'h01);
    wr(4'h0, 8'h01);
    wr(4'h6, 8'h01);
    shot(1'b1, 1'b1);
    check("irq at top", irq_req, 16'h1);
    wr(4'h6, 8'h01);
    shot(1'b0, 1'b0);
    wr(4'h4, 8'h11);
    shot(1'b1, 1'b1);
    shot(1'b0, 1'b1);
    wr(4'h1, 8'h16);
    shot(1'b1, 1'b1);
    $display("single shot test done");
  endtask : test_shot
  task automatic test_modes();
    logic [7:0] q;
    logic ok;
    // pulse width with noise canceller
    ev_want <= 1'b0;
    wr(4'h0, 8'h00);
    wr(4'h4, 8'h41);
    wr(4'h1, 8'h04);
    wr(4'h0, 8'h01);
    wr(4'h6, 8'h01);
    ev_want <= 1'b1;
    repeat (12) @(posedge mclk);
    check("width init", irq_req, 16'h0);
    repeat (20) @(posedge mclk);
    ev_want <= 1'b0;
    repeat (12) @(posedge mclk);
    check("width flag", irq_req, 16'h1);
    bus(1'b0, 4'hC, 8'h00, q);
    ok = q >= 8'd28 && q <= 8'd34;
    check("width value", ok, 16'h1);
    // a two-cycle glitch must not get past the canceller
    ev_want <= 1'b1;
    repeat (2) @(posedge mclk);
    ev_want <= 1'b0;
    repeat (12) @(posedge mclk);
    check("glitch", irq_req, 16'h0);
    // capture on falling edge
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h02);
    wr(4'h4, 8'h11);
    wr(4'h0, 8'h01);
    wr(4'h6, 8'h01);
    ev_want <= 1'b1;
    repeat (8) @(posedge mclk);
    check("capture rise", irq_req, 16'h0);
    ev_want <= 1'b0;
    repeat (8) @(posedge mclk);
    check("capture fall", irq_req, 16'h1);
    // timeout check: rise starts, fall stops
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h01);
    wr(4'h4, 8'h01);
    wr(4'h0, 8'h01);
    rd(4'h7, 8'h00);
    ev_want <= 1'b1;
    repeat (8) @(posedge mclk);
    rd(4'h7, 8'h01);
    ev_want <= 1'b0;
    repeat (8) @(posedge mclk);
    rd(4'h7, 8'h00);
    // frequency plus pulse width
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h05);
    wr(4'h0, 8'h01);
    wr(4'h6, 8'h01);
    ev_want <= 1'b1;
    repeat (8) @(posedge mclk);
    rd(4'h7, 8'h01);
    ev_want <= 1'b0;
    repeat (8) @(posedge mclk);
    check("fp capture", irq_req, 16'h0);
    ev_want <= 1'b1;
    repeat (8) @(posedge mclk);
    check("fp stop", irq_req, 16'h1);
    rd(4'h7, 8'h00);
    wr(4'h0, 8'h00);
    $display("mode test done");
  endtask : test_modes
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    test_regs();
    test_clock();
    test_output();
    test_freq();
    test_shot();
    test_modes();
    end_of_test();
  end
endmodule : tb_top
